// File: rtl/pemc_pkg.sv
package pemc_pkg;

  // clock period of i_ref_clk in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // device timing figures in their own units
  localparam int unsigned PROG_CYCLE_STD_MS  = 10;
  localparam int unsigned PROG_CYCLE_FAST_MS = 3;
  localparam int unsigned BYTE_LOAD_WINDOW_US = 150;
  localparam int unsigned WRITE_PULSE_NS      = 100;
  localparam int unsigned WRITE_PULSE_HIGH_NS = 50;
  localparam int unsigned ADDR_HOLD_NS        = 50;
  localparam int unsigned READ_ACCESS_NS      = 150;
  localparam int unsigned OUTPUT_FLOAT_NS     = 50;

  // least times round up, longest times round down
  localparam int unsigned WP_CYC  = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WPH_CYC = (WRITE_PULSE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
  localparam int unsigned AH_CYC  = (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACC_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DF_CYC  = (OUTPUT_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BLW_CYC = (BYTE_LOAD_WINDOW_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned PROG_STD_CYC  = (PROG_CYCLE_STD_MS * 1000000) / CLK_PERIOD_PS
                                          * 1000;
  localparam int unsigned PROG_FAST_CYC = (PROG_CYCLE_FAST_MS * 1000000) / CLK_PERIOD_PS
                                          * 1000;

  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PAGE_LSB = 6;
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned TOGGLE_BIT = 6;

  // host command opcodes
  localparam logic [1:0] CMD_READ  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_ERASE = 2'h2;

  typedef struct packed {
    logic [1:0]        op;
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pemc_cmd_t;

  typedef struct packed {
    logic              chip_sel_n;
    logic              out_gate_n;
    logic              wr_strobe_n;
    logic              hv_gate;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_o;
    logic              data_oe;
  } pemc_pins_t;

endpackage

// File: rtl/pemc_timer.sv
`timescale 1ns/1ps
module pemc_timer
  import pemc_pkg::*;
#(
  parameter int unsigned WIDTH = 24
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  // control
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  // status
  output logic                  o_done
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             done_q;
  logic             done_d;

  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (i_load) begin
      cnt_d = i_count;
    end else if (cnt_q != '0) begin
      cnt_d  = cnt_q - 1'b1;
      done_d = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;

endmodule

// File: rtl/pemc_host.sv
`timescale 1ns/1ps
// Summary of operation
// - read: select and gate low, strobe high
// - write: select low, gate high, strobe low
// - erase: select, strobe low, gate high voltage
// - wait program cycle, 10 or 3 ms
// - next page byte within 150 us
// - page bytes share one page address
module pemc_host
  import pemc_pkg::*;
#(
  parameter int unsigned  PROG_CYC  = PROG_STD_CYC,
  parameter int unsigned  BLW_LIMIT = BLW_CYC,
  parameter int unsigned  TW        = 24
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  // command port
  input  wire pemc_cmd_t         i_cmd,
  input  wire logic              i_cmd_valid,
  output logic                   o_cmd_ready,
  output logic [DATA_W-1:0]      o_rd_data,
  output logic                   o_rd_valid,
  output logic                   o_page_err,
  output logic                   o_busy,
  // device pins
  input  wire logic [DATA_W-1:0] i_dev_data,
  output pemc_pins_t             o_pins
);

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_RDACC = 8'h02,
    ST_WRLO  = 8'h04,
    ST_WRHI  = 8'h08,
    ST_LOAD  = 8'h10,
    ST_PROG  = 8'h20,
    ST_POLL  = 8'h40,
    ST_FLOAT = 8'h80
  } pemc_state_t;

  function automatic logic [TW-1:0] cyc(input int unsigned n);
    cyc = TW'(n);
  endfunction

  pemc_state_t              st_q, st_d;
  pemc_pins_t               pins_q, pins_d;
  logic [DATA_W-1:0]        rdat_q, rdat_d;
  logic                     rval_q, rval_d;
  logic                     perr_q, perr_d;
  logic                     rdy_q, rdy_d;
  logic                     busy_q, busy_d;
  logic                     erase_q, erase_d;
  logic [ADDR_W-PAGE_LSB-1:0] page_q, page_d;
  logic [DATA_W-1:0]        last_q, last_d;
  logic                     last_cmd_q, last_cmd_d;
  logic [7:0]               sub_q, sub_d;
  logic                     tog_q, tog_d;
  logic                     tog_seen_q, tog_seen_d;
  logic                     tm_load;
  logic [TW-1:0]            tm_count;
  logic                     tm_done;

  pemc_timer #(.WIDTH(TW)) u_timer (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_load    (tm_load),
    .i_count   (tm_count),
    .o_done    (tm_done)
  );

  always_comb begin
    st_d       = st_q;
    pins_d     = pins_q;
    rdat_d     = rdat_q;
    rval_d     = 1'b0;
    perr_d     = 1'b0;
    rdy_d      = 1'b0;
    busy_d     = busy_q;
    erase_d    = erase_q;
    page_d     = page_q;
    last_d     = last_q;
    last_cmd_d = last_cmd_q;
    sub_d      = sub_q;
    tog_d      = tog_q;
    tog_seen_d = tog_seen_q;
    tm_load    = 1'b0;
    tm_count   = '0;
    case (st_q)
      ST_IDLE, ST_LOAD: begin
        rdy_d = 1'b1;
        if (st_q == ST_LOAD && tm_done) begin
          // window lapsed: device starts programming on its own
          st_d     = ST_PROG;
          rdy_d    = 1'b0;
          busy_d   = 1'b1;
          tm_load  = 1'b1;
          tm_count = cyc(PROG_CYC);
        end else if (i_cmd_valid && rdy_q) begin
          rdy_d = 1'b0;
          pins_d.addr = i_cmd.addr;
          if (i_cmd.op == CMD_READ) begin
            pins_d.chip_sel_n  = 1'b0;
            pins_d.out_gate_n  = 1'b0;
            pins_d.wr_strobe_n = 1'b1;
            pins_d.data_oe     = 1'b0;
            sub_d = 8'(ACC_CYC);
            st_d  = ST_RDACC;
          end else if (st_q == ST_LOAD && i_cmd.op == CMD_WRITE
                       && i_cmd.addr[ADDR_W-1:PAGE_LSB] != page_q) begin
            perr_d = 1'b1;
            rdy_d  = 1'b1;
          end else begin
            if (i_cmd.op == CMD_WRITE && st_q == ST_LOAD) begin
              pins_d.addr = i_cmd.addr;
            end
            erase_d    = (i_cmd.op == CMD_ERASE);
            page_d     = i_cmd.addr[ADDR_W-1:PAGE_LSB];
            last_d     = i_cmd.data;
            last_cmd_d = i_cmd.last || (i_cmd.op == CMD_ERASE);
            pins_d.out_gate_n  = 1'b1;
            pins_d.hv_gate     = (i_cmd.op == CMD_ERASE);
            pins_d.chip_sel_n  = 1'b0;
            pins_d.wr_strobe_n = 1'b0;
            pins_d.data_o      = i_cmd.data;
            pins_d.data_oe     = (i_cmd.op != CMD_ERASE);
            sub_d = 8'(WP_CYC);
            st_d  = ST_WRLO;
          end
        end
      end
      ST_RDACC: begin
        if (sub_q > 8'h1) begin
          sub_d = sub_q - 8'h1;
        end else begin
          rdat_d = i_dev_data;
          rval_d = 1'b1;
          pins_d.out_gate_n = 1'b1;
          pins_d.chip_sel_n = 1'b1;
          sub_d = 8'(DF_CYC);
          st_d  = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        if (sub_q > 8'h1) begin
          sub_d = sub_q - 8'h1;
        end else begin
          st_d  = ST_IDLE;
          rdy_d = 1'b1;
        end
      end
      ST_WRLO: begin
        if (sub_q > 8'h1) begin
          sub_d = sub_q - 8'h1;
        end else begin
          pins_d.wr_strobe_n = 1'b1;
          sub_d = 8'(WPH_CYC > AH_CYC ? WPH_CYC : AH_CYC);
          st_d  = ST_WRHI;
        end
      end
      ST_WRHI: begin
        if (sub_q > 8'h1) begin
          sub_d = sub_q - 8'h1;
        end else begin
          pins_d.data_oe    = 1'b0;
          pins_d.hv_gate    = 1'b0;
          pins_d.chip_sel_n = 1'b1;
          tm_load = 1'b1;
          busy_d  = 1'b1;
          if (last_cmd_q) begin
            tm_count = cyc(PROG_CYC);
            st_d     = ST_PROG;
          end else begin
            tm_count = cyc(BLW_LIMIT);
            st_d     = ST_LOAD;
            rdy_d    = 1'b1;
          end
        end
      end
      ST_PROG: begin
        // poll the last byte written until the device reports done or the timer ends while in ST_PROG between polls; an erase only waits for the timer
        if (!erase_q && sub_q == 8'h0) begin
          pins_d.chip_sel_n  = 1'b0;
          pins_d.out_gate_n  = 1'b0;
          pins_d.wr_strobe_n = 1'b1;
          sub_d = 8'(ACC_CYC);
          st_d  = ST_POLL;
        end else if (sub_q != 8'h0) begin
          sub_d = sub_q - 8'h1;
        end
        if (tm_done) begin
          pins_d.chip_sel_n = 1'b1;
          pins_d.out_gate_n = 1'b1;
          busy_d     = 1'b0;
          tog_seen_d = 1'b0;
          sub_d      = 8'(DF_CYC);
          st_d       = ST_FLOAT;
        end
      end
      ST_POLL: begin
        if (sub_q > 8'h1) begin
          sub_d = sub_q - 8'h1;
        end else begin
          pins_d.chip_sel_n = 1'b1;
          pins_d.out_gate_n = 1'b1;
          tog_d      = i_dev_data[TOGGLE_BIT];
          tog_seen_d = 1'b1;
          sub_d      = 8'(DF_CYC);
          st_d       = ST_PROG;
          if (i_dev_data[POLL_BIT] == last_q[POLL_BIT]
              && tog_seen_q && i_dev_data[TOGGLE_BIT] == tog_q) begin
            busy_d     = 1'b0;
            tog_seen_d = 1'b0;
            st_d       = ST_FLOAT;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_q       <= ST_IDLE;
      pins_q     <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, wr_strobe_n: 1'b1,
                      hv_gate: 1'b0, addr: '0, data_o: '0, data_oe: 1'b0};
      rdat_q     <= '0;
      rval_q     <= 1'b0;
      perr_q     <= 1'b0;
      rdy_q      <= 1'b0;
      busy_q     <= 1'b0;
      erase_q    <= 1'b0;
      page_q     <= '0;
      last_q     <= '0;
      last_cmd_q <= 1'b0;
      sub_q      <= '0;
      tog_q      <= 1'b0;
      tog_seen_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      pins_q     <= pins_d;
      rdat_q     <= rdat_d;
      rval_q     <= rval_d;
      perr_q     <= perr_d;
      rdy_q      <= rdy_d;
      busy_q     <= busy_d;
      erase_q    <= erase_d;
      page_q     <= page_d;
      last_q     <= last_d;
      last_cmd_q <= last_cmd_d;
      sub_q      <= sub_d;
      tog_q      <= tog_d;
      tog_seen_q <= tog_seen_d;
    end
  end

  assign o_pins      = pins_q;
  assign o_rd_data   = rdat_q;
  assign o_rd_valid  = rval_q;
  assign o_page_err  = perr_q;
  assign o_cmd_ready = rdy_q;
  assign o_busy      = busy_q;

endmodule

// File: bench/pemc_props.sv
`timescale 1ns/1ps
module pemc_props
  import pemc_pkg::*;
#(
  parameter int unsigned PROG_CYC  = 500,
  parameter int unsigned BLW_LIMIT = 200
) (
  // watched ports
  input wire logic              i_ref_clk,
  input wire logic              i_reset,
  input wire pemc_cmd_t         i_cmd,
  input wire logic              i_cmd_valid,
  input wire logic              o_cmd_ready,
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire logic              o_rd_valid,
  input wire logic              o_page_err,
  input wire logic              o_busy,
  input wire logic [DATA_W-1:0] i_dev_data,
  input wire pemc_pins_t        o_pins
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  wire logic rd_take = i_cmd_valid && o_cmd_ready && i_cmd.op == CMD_READ;
  property p_wr_gate; !o_pins.wr_strobe_n |-> o_pins.out_gate_n; endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("strobe low, gate low");
  property p_wr_sel; !o_pins.wr_strobe_n |-> !o_pins.chip_sel_n; endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("strobe low, deselected");
  property p_oe_gate; o_pins.data_oe |-> o_pins.out_gate_n; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("bus contention");
  property p_rd;
    !o_pins.out_gate_n |-> o_pins.wr_strobe_n && !o_pins.data_oe && !o_pins.chip_sel_n;
  endproperty
  a_rd: assert property (p_rd) else $error("bad read strobes");
  property p_erase; o_pins.hv_gate |-> !o_pins.data_oe && o_pins.out_gate_n; endproperty
  a_erase: assert property (p_erase) else $error("bad erase pins");
  property p_rdv; rd_take |-> ##31 o_rd_valid; endproperty
  a_rdv: assert property (p_rdv) else $error("read answer late");
  property p_rdsrc; o_rd_valid |-> $past(o_pins.out_gate_n) == 1'b0; endproperty
  a_rdsrc: assert property (p_rdsrc) else $error("read without gate");
  property p_wp;
    $fell(o_pins.wr_strobe_n) && !o_pins.hv_gate |-> (!o_pins.wr_strobe_n) [*8];
  endproperty
  a_wp: assert property (p_wp) else $error("write pulse short");
  c_rd: cover property (rd_take);
  c_busy: cover property ($rose(o_busy));
  c_err: cover property (o_page_err);
endmodule
bind pemc_host pemc_props #(.PROG_CYC(PROG_CYC), .BLW_LIMIT(BLW_LIMIT)) u_props (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cmd(i_cmd), .i_cmd_valid(i_cmd_valid),
  .o_cmd_ready(o_cmd_ready), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
  .o_page_err(o_page_err), .o_busy(o_busy), .i_dev_data(i_dev_data), .o_pins(o_pins));

// File: bench/pemc_dev.sv
`timescale 1ns/1ps
module pemc_dev
  import pemc_pkg::*;
#(
  parameter int unsigned PROG_CYC = 500
) (
  // clock and pins
  input  wire logic         i_ref_clk,
  input  wire pemc_pins_t   i_pins,
  output logic [DATA_W-1:0] o_data
);
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] last_q, hold_q;
  logic              tog_q, wr_n_q, gate_n_q, hv_q;
  int                cnt_q;
  wire logic rd = !i_pins.chip_sel_n && !i_pins.out_gate_n && i_pins.wr_strobe_n;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    {last_q, hold_q, tog_q, hv_q, cnt_q} = '0;
    {wr_n_q, gate_n_q} = 2'h3;
  end
  always @(posedge i_ref_clk) begin
    wr_n_q <= i_pins.wr_strobe_n;
    gate_n_q <= i_pins.out_gate_n;
    hv_q <= i_pins.hv_gate;
    if (cnt_q != 0) cnt_q <= cnt_q - 1;
    if (rd && gate_n_q && cnt_q != 0) tog_q <= !tog_q;
    // latch on strobe rise only while selected; a write also needs gate high, an erase does not
    if (i_pins.wr_strobe_n && !wr_n_q && !i_pins.chip_sel_n) begin
      if (i_pins.hv_gate || hv_q) begin
        foreach (mem[i]) mem[i] <= 8'hff;
        cnt_q <= PROG_CYC;
      end else if (i_pins.out_gate_n) begin
        mem[i_pins.addr[7:0]] <= i_pins.data_o;
        last_q <= i_pins.data_o;
        cnt_q <= PROG_CYC;
      end
    end
    if (rd) hold_q <= o_data;
  end
  always_comb begin
    if (!rd) o_data = ~hold_q;
    else if (cnt_q != 0) o_data = {~last_q[7], tog_q, last_q[5:0]};
    else o_data = mem[i_pins.addr[7:0]];
  end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb
  import pemc_pkg::*;
;
  localparam int unsigned PC = 500;
  localparam int unsigned BW = 200;
  logic              clk, rst, vld, rdy, rdv, perr, busy;
  pemc_cmd_t         cmd;
  logic [DATA_W-1:0] rdat, ddat;
  pemc_pins_t        pins;
  int                error_cnt, n_checks, perr_n;
  pemc_host #(.PROG_CYC(PC), .BLW_LIMIT(BW), .TW(24)) u_dut (
    .i_ref_clk(clk), .i_reset(rst), .i_cmd(cmd), .i_cmd_valid(vld), .o_cmd_ready(rdy),
    .o_rd_data(rdat), .o_rd_valid(rdv), .o_page_err(perr), .o_busy(busy),
    .i_dev_data(ddat), .o_pins(pins));
  // device finishes well inside the host timer, so polling must end each write
  pemc_dev #(.PROG_CYC(PC / 2)) u_dev (.i_ref_clk(clk), .i_pins(pins), .o_data(ddat));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) if (perr === 1'b1) perr_n++;
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic send(logic [1:0] op, logic lst, logic [14:0] a, logic [7:0] d);
    @(negedge clk);
    cmd = '{op: op, last: lst, addr: a, data: d};
    vld = 1;
    while (rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    vld = 0;
  endtask
  task automatic idle();
    while (busy !== 1'b0 || rdy !== 1'b1) @(negedge clk);
    chk("idle_pins", 16'h1c, {pins.chip_sel_n, pins.out_gate_n, pins.wr_strobe_n,
        pins.hv_gate, pins.data_oe});
  endtask
  task automatic rd_chk(logic [14:0] a, logic [7:0] exp);
    int n;
    send(CMD_READ, 0, a, 8'h00);
    for (n = 0; n < 40 && rdv !== 1'b1; n++) @(negedge clk);
    chk("rd_valid", 1, rdv);
    chk("rd_data", exp, rdat);
  endtask
  task automatic t_reset();
    rst = 1;
    repeat (2) @(negedge clk);
    chk("rst_pins", 16'h70, {pins.chip_sel_n, pins.out_gate_n, pins.wr_strobe_n,
        pins.hv_gate, pins.data_oe, rdy, busy});
    rst = 0;
    @(negedge clk);
    chk("ready_1st", 1, rdy);
    @(negedge clk);
    chk("ready_2nd", 1, rdy);
    $display("t_reset done");
  endtask
  task automatic t_wr_rd();
    int n;
    send(CMD_WRITE, 1, 15'h0005, 8'ha5);
    repeat (40) @(negedge clk);
    chk("busy_wr", 1, busy);
    for (n = 40; n < PC && busy === 1'b1; n++) @(negedge clk);
    chk("poll_end", 1, n < PC - 100);
    idle();
    rd_chk(15'h0005, 8'ha5);
    $display("t_wr_rd done");
  endtask
  task automatic t_page();
    send(CMD_WRITE, 0, 15'h0040, 8'h3c);
    send(CMD_WRITE, 0, 15'h0085, 8'h77);
    send(CMD_WRITE, 1, 15'h007f, 8'hc3);
    chk("page_err", 1, perr_n);
    idle();
    rd_chk(15'h0040, 8'h3c);
    rd_chk(15'h007f, 8'hc3);
    rd_chk(15'h0085, 8'h00);
    $display("t_page done");
  endtask
  task automatic t_lapse();
    send(CMD_WRITE, 0, 15'h0101, 8'h5a);
    repeat (32 + BW + 20) @(negedge clk);
    chk("busy_lapse", 1, busy);
    idle();
    rd_chk(15'h0101, 8'h5a);
    $display("t_lapse done");
  endtask
  task automatic t_erase();
    send(CMD_ERASE, 1, 15'h0000, 8'h00);
    repeat (40) @(negedge clk);
    chk("busy_erase", 1, busy);
    idle();
    rd_chk(15'h0005, 8'hff);
    $display("t_erase done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    {rst, vld, cmd, error_cnt, n_checks, perr_n} = '0;
    rst = 1;
    t_reset();
    t_wr_rd();
    t_page();
    t_lapse();
    t_reset();
    t_erase();
    results();
  end
endmodule
